// file: pstg_far_end.sv
`default_nettype none
module pstg_far_end (
	input  wire logic       clk_i,
	input  wire logic       rd_strobe_n_i,
	output var  logic [7:0] pins_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic       prev_reg;
	logic [7:0] pins_reg = 8'h5A;
	assign pins_o = pins_reg;
	// New byte only once the pulse is over, never during it
	always_ff @(posedge clk_i) begin
		prev_reg <= rd_strobe_n_i;
		if (rd_strobe_n_i && !prev_reg)
			pins_reg <= 8'($urandom);
	end
endmodule : pstg_far_end
`default_nettype wire

// file: pstg_pkg.sv
`default_nettype none
package pstg_pkg;
	localparam int unsigned PSTG_DATA_W = 8;
	// Delay from port access to strobe assertion, in clock cycles
	localparam logic [2:0] PSTG_WR_DELAY = 3'h2;
	localparam logic [2:0] PSTG_RD_DELAY = 3'h3;
	// Strobe width in clock cycles
	localparam logic [2:0] PSTG_STB_LEN = 3'h2;
	localparam logic [2:0] PSTG_CNT_ONE = 3'h1;
	localparam logic [2:0] PSTG_CNT_ZERO = 3'h0;
	typedef enum logic [1:0] {
		PSTG_IDLE,
		PSTG_WAIT,
		PSTG_PULSE
	} pstg_state_t;
endpackage : pstg_pkg
`default_nettype wire

// file: pstg_port_strobe_generator.sv
`default_nettype none
// Notes on behaviour
// - Strobes pulse on port accesses only while strobe enable is set.
// - Each strobe stays asserted exactly two clock cycles, then deasserts.
// - Write strobe starts two cycles after the port output value updates.
// - Read returns the pin value captured three cycles before read strobe.
// - After a read, wait three cycles, then pulse read strobe two cycles.
// - Read strobe assertion samples nothing; it only signals prefetch.
module pstg_port_strobe_generator
	import pstg_pkg::*;
(
	input  wire logic                   ref_clk_i,
	input  wire logic                   rst_n_i,
	input  wire logic                   port_strobe_enable_i,
	input  wire logic                   cpu_wr_i,
	input  wire logic [PSTG_DATA_W-1:0] cpu_wdata_i,
	input  wire logic                   cpu_rd_i,
	input  wire logic [PSTG_DATA_W-1:0] port_pins_i,
	output var  logic [PSTG_DATA_W-1:0] port_out_o,
	output var  logic [PSTG_DATA_W-1:0] cpu_rdata_o,
	output var  logic                   wr_strobe_n_o,
	output var  logic                   rd_strobe_n_o
);
	pstg_state_t state_reg;
	pstg_state_t state_next;
	logic [2:0]  cnt_reg;
	logic [2:0]  cnt_next;
	logic        is_rd_reg;
	logic        is_rd_next;

	// Access decode; a read and a write in one cycle counts as a write
	wire logic       access_w        = cpu_wr_i || cpu_rd_i;
	wire logic       rd_only_w       = cpu_rd_i && !cpu_wr_i;
	wire logic       idle_w          = (state_reg == PSTG_IDLE);

	// A new access is taken only from idle; accesses during a strobe
	// sequence still update data but do not restart the strobe.
	wire logic       start_w         = idle_w && port_strobe_enable_i
		&& access_w;

	// Counts down so the strobe falls on the chosen edge
	wire logic [2:0] delay_w         = rd_only_w ? PSTG_RD_DELAY
		: PSTG_WR_DELAY;
	wire logic       cnt_end_w       = (cnt_reg == PSTG_CNT_ONE);

	// Strobes decode the next state so each leaves a flip-flop
	wire logic       pulse_next_w    = (state_next == PSTG_PULSE);
	wire logic       wr_pulse_next_w = pulse_next_w && !is_rd_next;
	wire logic       rd_pulse_next_w = pulse_next_w && is_rd_next;

	always_comb begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		is_rd_next = is_rd_reg;
		case (state_reg)
			PSTG_IDLE: begin
				if (start_w) begin
					state_next = PSTG_WAIT;
					is_rd_next = rd_only_w;
					cnt_next = delay_w;
				end
			end
			PSTG_WAIT: begin
				if (cnt_end_w) begin
					state_next = PSTG_PULSE;
					cnt_next = PSTG_STB_LEN;
				end else begin
					cnt_next = cnt_reg - PSTG_CNT_ONE;
				end
			end
			PSTG_PULSE: begin
				if (cnt_end_w) begin
					state_next = PSTG_IDLE;
					cnt_next = PSTG_CNT_ZERO;
				end else begin
					cnt_next = cnt_reg - PSTG_CNT_ONE;
				end
			end
			default: begin
				state_next = PSTG_IDLE;
				cnt_next = PSTG_CNT_ZERO;
			end
		endcase
	end

	// Sequencer; a busy access is dropped rather than queued
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			state_reg <= PSTG_IDLE;
			cnt_reg   <= PSTG_CNT_ZERO;
			is_rd_reg <= 1'h0;
		end else begin
			state_reg <= state_next;
			cnt_reg   <= cnt_next;
			is_rd_reg <= is_rd_next;
		end
	end

	// Output value follows every write, strobed or not
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			port_out_o <= '0;
		end else if (cpu_wr_i) begin
			port_out_o <= cpu_wdata_i;
		end
	end

	// Pins latched at the read itself, three cycles ahead of the strobe
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			cpu_rdata_o <= '0;
		end else if (cpu_rd_i) begin
			cpu_rdata_o <= port_pins_i;
		end
	end

	// Strobes sit high through reset so no false pulse leaves the block
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			wr_strobe_n_o <= 1'h1;
			rd_strobe_n_o <= 1'h1;
		end else begin
			wr_strobe_n_o <= !wr_pulse_next_w;
			rd_strobe_n_o <= !rd_pulse_next_w;
		end
	end

	a_wr_strobe_delay: assert property (@(posedge ref_clk_i)
		disable iff (!rst_n_i)
		(start_w && cpu_wr_i)
		|-> ##1 wr_strobe_n_o [*2] ##1 !wr_strobe_n_o)
		else $error("write strobe not two cycles after write");

	a_rd_strobe_delay: assert property (@(posedge ref_clk_i)
		disable iff (!rst_n_i)
		(start_w && rd_only_w)
		|-> ##1 rd_strobe_n_o [*3] ##1 !rd_strobe_n_o)
		else $error("read strobe not three cycles after read");

	a_strobe_width: assert property (@(posedge ref_clk_i)
		disable iff (!rst_n_i)
		$fell(wr_strobe_n_o)
		|-> ##1 !wr_strobe_n_o ##1 wr_strobe_n_o)
		else $error("write strobe width not two cycles");

	a_rd_width: assert property (@(posedge ref_clk_i)
		disable iff (!rst_n_i)
		$fell(rd_strobe_n_o)
		|-> ##1 !rd_strobe_n_o ##1 rd_strobe_n_o)
		else $error("read strobe width not two cycles");

	a_enable_gate: assert property (@(posedge ref_clk_i)
		disable iff (!rst_n_i)
		(idle_w && !port_strobe_enable_i)
		|=> idle_w && rd_strobe_n_o && wr_strobe_n_o)
		else $error("strobe while disabled");

	a_rd_capture: assert property (@(posedge ref_clk_i)
		disable iff (!rst_n_i)
		cpu_rd_i
		|=> cpu_rdata_o == $past(port_pins_i))
		else $error("read data not captured at read");

	a_strobe_excl: assert property (@(posedge ref_clk_i)
		disable iff (!rst_n_i)
		!(!rd_strobe_n_o && !wr_strobe_n_o))
		else $error("both strobes low");

	a_wr_data_stable: assert property (@(posedge ref_clk_i)
		disable iff (!rst_n_i)
		(start_w && cpu_wr_i)
		|=> port_out_o == $past(cpu_wdata_i))
		else $error("port output not updated before strobe");

	a_wr_seq_len: assert property (@(posedge ref_clk_i)
		disable iff (!rst_n_i)
		(start_w && cpu_wr_i)
		|=> !idle_w [*4] ##1 idle_w)
		else $error("write sequence length wrong");

	a_rd_seq_len: assert property (@(posedge ref_clk_i)
		disable iff (!rst_n_i)
		(start_w && rd_only_w)
		|=> !idle_w [*5] ##1 idle_w)
		else $error("read sequence length wrong");

	a_rd_hold_data: assert property (@(posedge ref_clk_i)
		disable iff (!rst_n_i)
		($fell(rd_strobe_n_o) && !$past(cpu_rd_i))
		|-> $stable(cpu_rdata_o))
		else $error("read data sampled at read strobe");

	a_idle_strobe_high: assert property (@(posedge ref_clk_i)
		disable iff (!rst_n_i)
		(state_reg != PSTG_PULSE)
		|-> wr_strobe_n_o && rd_strobe_n_o)
		else $error("strobe low outside pulse");

	a_rd_strobe_kind: assert property (@(posedge ref_clk_i)
		disable iff (!rst_n_i)
		!rd_strobe_n_o
		|-> is_rd_reg)
		else $error("read strobe for a write");

	a_wr_strobe_kind: assert property (@(posedge ref_clk_i)
		disable iff (!rst_n_i)
		!wr_strobe_n_o
		|-> !is_rd_reg)
		else $error("write strobe for a read");

	a_out_only_write: assert property (@(posedge ref_clk_i)
		disable iff (!rst_n_i)
		!cpu_wr_i
		|=> $stable(port_out_o))
		else $error("port output changed without write");

	a_pulse_entry: assert property (@(posedge ref_clk_i)
		disable iff (!rst_n_i)
		(state_reg == PSTG_WAIT && cnt_end_w)
		|=> state_reg == PSTG_PULSE)
		else $error("pulse not entered after wait");

	a_pulse_exit: assert property (@(posedge ref_clk_i)
		disable iff (!rst_n_i)
		(state_reg == PSTG_PULSE && cnt_end_w)
		|=> idle_w)
		else $error("pulse not ended after two cycles");
endmodule : pstg_port_strobe_generator
`default_nettype wire

// file: tb_port_strobe_generator.sv
`default_nettype none
module tb_port_strobe_generator;
	timeunit 1ns;
	timeprecision 1ns;
	logic       ref_clk_i = 1'b0, rst_n_i = 1'b0, en = 1'b0;
	logic       wr = 1'b0, rd = 1'b0, wst_n, rst_n;
	logic [7:0] wdata = 8'h00, pins, pout, rdata;
	logic [8:0] q[$];
	int         err_count = 0, checks_done = 0;
	pstg_port_strobe_generator dut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
		.port_strobe_enable_i(en), .cpu_wr_i(wr), .cpu_wdata_i(wdata),
		.cpu_rd_i(rd), .port_pins_i(pins), .port_out_o(pout),
		.cpu_rdata_o(rdata), .wr_strobe_n_o(wst_n), .rd_strobe_n_o(rst_n));
	pstg_far_end far (.clk_i(ref_clk_i), .rd_strobe_n_i(rst_n), .pins_o(pins));
	initial forever #20 ref_clk_i = ~ref_clk_i;
	task automatic check(input logic [8:0] seen, input logic [8:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_count++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic finish_test;
		$display("errors=%0d checks=%0d", err_count, checks_done);
		if (err_count == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : finish_test
	// Strobe level after each of six edges; a refused access stays high
	task automatic access(input logic is_rd, input logic ena,
		input logic both);
		logic [5:0] seen;
		logic [7:0] v;
		v = 8'($urandom);
		@(posedge ref_clk_i);
		en <= ena;
		wr <= !is_rd;
		rd <= is_rd || both;
		wdata <= v;
		for (int k = 0; k < 6; k++) begin
			@(posedge ref_clk_i);
			// Pins as the block samples them at this very edge
			if (k == 0 && ena)
				q.push_back({is_rd, is_rd ? pins : v});
			wr <= 1'b0;
			rd <= 1'b0;
			@(negedge ref_clk_i);
			seen[k] = is_rd ? rst_n : wst_n;
		end
		check({3'h0, seen}, !ena ? 9'h03F : is_rd ? 9'h027 : 9'h033);
	endtask : access
	initial begin
		logic       pw, pr;
		logic [8:0] e;
		pw = 1'b1;
		pr = 1'b1;
		forever begin
			@(negedge ref_clk_i);
			if ((pw && !wst_n) || (pr && !rst_n)) begin
				e = q.pop_front();
				check({e[8], e[8] ? rdata : pout}, e);
			end
			pw = wst_n;
			pr = rst_n;
		end
	end
	initial begin
		void'($urandom(32'h14C6));
		repeat (10) @(posedge ref_clk_i);
		rst_n_i <= 1'b1;
		for (int i = 0; i < 14; i++)
			access(i[0], i % 5 != 4, i == 6);
		repeat (3) @(posedge ref_clk_i);
		check(9'(q.size()), 9'h000);
		finish_test();
	end
	initial begin
		#100us;
		err_count++;
		finish_test();
	end
endmodule : tb_port_strobe_generator
`default_nettype wire
